// >>> erc_decoder.sv
`timescale 1ns/1ps
`include "erc_consts.svh"
module erc_decoder
    import erc_pkg::*;
#(
    parameter int unsigned AUD_W = `ERC_AUD_W,   // Audio sample width
    parameter int unsigned DAC_W = `ERC_DAC_W    // Power sample width
)
(
    input  wire logic                      clk_i,
    input  wire logic                      rstn_i,
    // Controller pins, asynchronous
    input  wire logic [`ERC_CH_SEL_W-1:0]  channel_choice_lines_i,
    input  wire logic [1:0]                mode_sel_i,
    input  wire logic                      fsk_symbol_bit_a_i,
    input  wire logic                      fsk_symbol_bit_b_i,
    input  wire logic                      fsk_bit_d_or_strobe_i,
    input  wire logic                      key_i,
    input  wire logic                      pa_low_power_mode_i,
    // Microcontroller side, same clock
    input  wire logic [AUD_W-1:0]          audio_sample_i,
    input  wire logic                      audio_valid_i,
    input  wire logic [DAC_W-1:0]          power_data_i,
    input  wire logic                      power_wr_fwd_i,
    input  wire logic                      power_wr_ref_i,
    input  wire erc_status_s               status_i,
    // Decoded values to the microcontroller
    output logic [`ERC_CH_NUM_W-1:0]       channel_o,
    output erc_mode_e                      mode_o,
    output logic                           mode_invalid_o,
    output logic                           key_o,
    output logic                           pa_low_power_o,
    output logic [`ERC_FSK_W-1:0]          fsk_data_o,
    // Serial audio link to the modulator
    output logic                           link_clk_o,
    output logic                           link_frame_o,
    output logic                           link_data_o,
    output logic                           audio_busy_o,
    // Power samples and alarm lines to the controller
    output logic [DAC_W-1:0]               forward_power_level_o,
    output logic [DAC_W-1:0]               reflected_power_level_o,
    output logic                           fault_alarm_o,
    output logic                           mismatch_flag_o,
    output logic                           low_power_alarm_o,
    output logic                           shutdown_alarm_o,
    output logic                           temp_alarm_o,
    output logic                           rf_input_alarm_o,
    output logic                           modulation_present_flag_o,
    output logic                           tone_decoder_o
);
    localparam int unsigned NPIN = `ERC_CH_SEL_W + 7;   // Pins through synchroniser

    // Channel number from active-low bits
    function automatic logic [`ERC_CH_NUM_W-1:0] ch_num(input logic [`ERC_CH_SEL_W-1:0] s);
        ch_num = `ERC_CH_BASE + {1'b0, ~s};
    endfunction : ch_num

    // Two-stage synchroniser on every controller pin
    logic [NPIN-1:0] meta_q, sync_q;
    logic [NPIN-1:0] pins;
    // Channel lines rest open (high); others rest low so release keeps analog, key off
    localparam logic [NPIN-1:0] SYNC_IDLE = {{`ERC_CH_SEL_W{1'b1}},
                                             {(NPIN-`ERC_CH_SEL_W){1'b0}}};
    assign pins = {channel_choice_lines_i, mode_sel_i, fsk_symbol_bit_a_i,
                   fsk_symbol_bit_b_i, fsk_bit_d_or_strobe_i, key_i, pa_low_power_mode_i};

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= SYNC_IDLE;   // Idle levels, no false mode or key after reset
            sync_q <= SYNC_IDLE;
        end
        else
        begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    // Unpack synchronised pins
    logic [`ERC_CH_SEL_W-1:0] s_ch;
    logic [1:0]               s_mode;
    logic                     s_da, s_db, s_dd, s_key, s_lpm;
    assign {s_ch, s_mode, s_da, s_db, s_dd, s_key, s_lpm} = sync_q;

    // Decode state
    logic [`ERC_CH_NUM_W-1:0] ch_d, ch_q;
    erc_mode_e                mode_d, mode_q;
    logic                     inv_d, inv_q;
    logic [`ERC_FSK_W-1:0]    fsk_d, fsk_q;
    erc_status_s              st_d, st_q;
    logic                     key_q, lpm_q;

    // Channel, mode and FSK decode
    always_comb
    begin
        ch_d   = ch_num(s_ch);
        mode_d = mode_q;
        inv_d  = 1'b0;
        case ({s_mode[`ERC_MODE_B2], s_mode[`ERC_MODE_B1]})
            2'b00:   mode_d = ERC_MODE_ANALOG;
            2'b01:   mode_d = ERC_MODE_FSK2;
            2'b11:   mode_d = ERC_MODE_FSK4;
            default: inv_d  = 1'b1;
        endcase
        // Only bits a and b are live; upper bits strapped low
        fsk_d = {2'b00, s_db, s_da};
        st_d  = status_i;
    end

    // Decode registers
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ch_q   <= `ERC_CH_BASE;
            mode_q <= ERC_MODE_ANALOG;
            inv_q  <= 1'b0;
            fsk_q  <= '0;
            st_q   <= '0;
            key_q  <= 1'b0;
            lpm_q  <= 1'b0;
        end
        else
        begin
            ch_q   <= ch_d;
            mode_q <= mode_d;
            inv_q  <= inv_d;
            fsk_q  <= fsk_d;
            st_q   <= st_d;
            key_q  <= s_key;
            lpm_q  <= s_lpm;
        end
    end

    // Serial audio link: reference-rate clock, MSB first
    typedef enum logic [1:0] { ERC_L_IDLE, ERC_L_SHIFT } erc_link_e;
    erc_link_e          ls_d, ls_q;
    logic [`ERC_DIV_W-1:0] div_d, div_q;
    logic               lclk_d, lclk_q;
    logic [AUD_W-1:0]   sh_d, sh_q;
    logic [`ERC_BIT_W-1:0] bit_d, bit_q;
    logic               frm_d, frm_q;
    logic               busy_d, busy_q;
    logic               dat_d, dat_q;     // Registered serial bit

    // Link sequencer; samples offered while busy are dropped
    always_comb
    begin
        ls_d   = ls_q;
        div_d  = div_q;
        lclk_d = lclk_q;
        sh_d   = sh_q;
        bit_d  = bit_q;
        frm_d  = frm_q;
        busy_d = busy_q;
        // Divider runs free so the clock derives from the reference
        if (div_q == `ERC_DIV_W'(`ERC_LINK_DIV - 1))
        begin
            div_d  = '0;
            lclk_d = ~lclk_q;
        end
        else
            div_d = div_q + 1'b1;
        case (ls_q)
            ERC_L_IDLE:
            begin
                if (audio_valid_i && mode_q == ERC_MODE_ANALOG)
                begin
                    sh_d   = audio_sample_i;
                    bit_d  = `ERC_BIT_W'(AUD_W);
                    busy_d = 1'b1;
                    ls_d   = ERC_L_SHIFT;
                end
            end
            ERC_L_SHIFT:
            begin
                // Advance data on the falling link edge
                if (div_q == `ERC_DIV_W'(`ERC_LINK_DIV - 1) && lclk_q)
                begin
                    if (bit_q == '0)
                    begin
                        frm_d  = 1'b0;
                        busy_d = 1'b0;
                        ls_d   = ERC_L_IDLE;
                    end
                    else
                    begin
                        frm_d = 1'b1;
                        bit_d = bit_q - 1'b1;
                        if (frm_q)
                            sh_d = {sh_q[AUD_W-2:0], 1'b0};
                    end
                end
            end
            default: ls_d = ERC_L_IDLE;
        endcase
        // Bit is gated by the frame so the line rests low between frames
        dat_d = frm_d & sh_d[AUD_W-1];
    end

    // Link registers
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ls_q   <= ERC_L_IDLE;
            div_q  <= '0;
            lclk_q <= 1'b0;
            sh_q   <= '0;
            bit_q  <= '0;
            frm_q  <= 1'b0;
            busy_q <= 1'b0;
            dat_q  <= 1'b0;
        end
        else
        begin
            ls_q   <= ls_d;
            div_q  <= div_d;
            lclk_q <= lclk_d;
            sh_q   <= sh_d;
            bit_q  <= bit_d;
            frm_q  <= frm_d;
            busy_q <= busy_d;
            dat_q  <= dat_d;
        end
    end

    // Power sample steering into the dual converter
    erc_dac_if dac_bus ();
    assign dac_bus.data   = power_data_i;
    assign dac_bus.wr_fwd = power_wr_fwd_i & ~power_wr_ref_i;
    assign dac_bus.wr_ref = power_wr_ref_i & ~power_wr_fwd_i;

    erc_dual_dac u_dac
    (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .dac    (dac_bus.slave)
    );

    // Output mapping
    assign channel_o                 = ch_q;
    assign mode_o                    = mode_q;
    assign mode_invalid_o            = inv_q;
    assign key_o                     = key_q;
    assign pa_low_power_o            = lpm_q;
    assign fsk_data_o                = fsk_q;
    assign link_clk_o                = lclk_q;
    assign link_frame_o              = frm_q;
    assign link_data_o               = dat_q;
    assign audio_busy_o              = busy_q;
    assign forward_power_level_o     = dac_bus.fwd_q;
    assign reflected_power_level_o   = dac_bus.ref_q;
    assign fault_alarm_o             = st_q.fault;
    assign mismatch_flag_o           = st_q.mismatch;
    assign low_power_alarm_o         = st_q.low_power;
    assign shutdown_alarm_o          = st_q.shutdown;
    assign temp_alarm_o              = st_q.over_temp;
    assign rf_input_alarm_o          = st_q.rf_input;
    assign modulation_present_flag_o = st_q.modulation;
    assign tone_decoder_o            = st_q.tone;
endmodule : erc_decoder

// >>> erc_consts.svh
`ifndef ERC_CONSTS_SVH
`define ERC_CONSTS_SVH
// Channel decode
`define ERC_CH_SEL_W        3
`define ERC_CH_NUM_W        4
`define ERC_CH_BASE         4'h1
// Mode select field positions
`define ERC_MODE_B1         0
`define ERC_MODE_B2         1
// FSK bus width at the modulator
`define ERC_FSK_W           4
// Power sample width
`define ERC_DAC_W           8
// Audio sample width
`define ERC_AUD_W           16
// Reference and link timing
`define ERC_SYS_MHZ         125
`define ERC_REF_MHZ         10
`define ERC_LINK_DIV        ((`ERC_SYS_MHZ + 2 * `ERC_REF_MHZ - 1) / (2 * `ERC_REF_MHZ))
`define ERC_DIV_W           8
`define ERC_BIT_W           5
`endif

// >>> erc_pkg.sv
package erc_pkg;
    // Operating mode seen by the microcontroller
    typedef enum logic [1:0]
    {
        ERC_MODE_ANALOG,
        ERC_MODE_FSK2,
        ERC_MODE_FSK4,
        ERC_MODE_LOCAL
    } erc_mode_e;
    // Status alarms, one bit per line
    typedef struct packed
    {
        logic fault;
        logic mismatch;
        logic low_power;
        logic shutdown;
        logic over_temp;
        logic rf_input;
        logic modulation;
        logic tone;
    } erc_status_s;
endpackage : erc_pkg

// >>> erc_dac_if.sv
`timescale 1ns/1ps
`include "erc_consts.svh"
// Write path from the steering logic into the dual converter model
interface erc_dac_if;
    logic                  wr_fwd;   // Forward half strobe
    logic                  wr_ref;   // Reflected half strobe
    logic [`ERC_DAC_W-1:0] data;     // Shared write data
    logic [`ERC_DAC_W-1:0] fwd_q;    // Held forward value
    logic [`ERC_DAC_W-1:0] ref_q;    // Held reflected value
    modport master (output wr_fwd, output wr_ref, output data, input fwd_q, input ref_q);
    modport slave  (input wr_fwd, input wr_ref, input data, output fwd_q, output ref_q);
endinterface : erc_dac_if

// >>> erc_dual_dac.sv
`timescale 1ns/1ps
`include "erc_consts.svh"
// Two-word holding store for the dual converter halves
module erc_dual_dac
    import erc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    erc_dac_if.slave  dac
);
    logic [`ERC_DAC_W-1:0] fwd_d, fwd_q;   // Forward half
    logic [`ERC_DAC_W-1:0] ref_d, ref_q;   // Reflected half

    // Each strobe loads only its own half
    always_comb
    begin
        fwd_d = fwd_q;
        ref_d = ref_q;
        if (dac.wr_fwd)
            fwd_d = dac.data;
        if (dac.wr_ref)
            ref_d = dac.data;
    end

    // Registers
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            fwd_q <= '0;
            ref_q <= '0;
        end
        else
        begin
            fwd_q <= fwd_d;
            ref_q <= ref_d;
        end
    end

    assign dac.fwd_q = fwd_q;
    assign dac.ref_q = ref_q;
endmodule : erc_dual_dac

// >>> erc_link_rx.sv
`timescale 1ns/1ps
// Modulator end of the serial audio link
module erc_link_rx
(
    input  wire logic        clr_i,        // Clears before each frame
    input  wire logic        link_clk_i,   // Link clock from the block
    input  wire logic        link_frame_i, // Frame marker
    input  wire logic        link_data_i,  // Serial bit
    output logic      [15:0] word_o,       // Assembled sample
    output logic      [4:0]  bits_o        // Bits taken this frame
);
    // Sample on the rising link edge, only inside a frame
    always @(posedge link_clk_i or posedge clr_i)
    begin
        if (clr_i)
        begin
            word_o <= 16'h0000;
            bits_o <= 5'h00;
        end
        else if (link_frame_i)
        begin
            word_o <= {word_o[14:0], link_data_i};
            bits_o <= bits_o + 5'h01;
        end
    end
endmodule : erc_link_rx

// >>> erc_decoder_chk.sv
`timescale 1ns/1ps
// Watches decode latency, steering, alarms and link framing
module erc_decoder_chk
    import erc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic [2:0]  channel_choice_lines_i,
    input wire logic [1:0]  mode_sel_i,
    input wire logic        fsk_symbol_bit_a_i,
    input wire logic        fsk_symbol_bit_b_i,
    input wire logic        key_i,
    input wire logic        pa_low_power_mode_i,
    input wire logic        audio_valid_i,
    input wire logic [7:0]  power_data_i,
    input wire logic        power_wr_fwd_i,
    input wire logic        power_wr_ref_i,
    input wire erc_status_s status_i,
    input wire logic [3:0]  channel_o,
    input wire erc_mode_e   mode_o,
    input wire logic        mode_invalid_o,
    input wire logic        key_o,
    input wire logic        pa_low_power_o,
    input wire logic [3:0]  fsk_data_o,
    input wire logic        link_clk_o,
    input wire logic        link_frame_o,
    input wire logic        audio_busy_o,
    input wire logic [7:0]  forward_power_level_o,
    input wire logic [7:0]  reflected_power_level_o,
    input wire logic        fault_alarm_o,
    input wire logic        mismatch_flag_o,
    input wire logic        low_power_alarm_o,
    input wire logic        shutdown_alarm_o,
    input wire logic        temp_alarm_o,
    input wire logic        rf_input_alarm_o,
    input wire logic        modulation_present_flag_o,
    input wire logic        tone_decoder_o
);
    logic [2:0] up_q;   // Cycles since reset; pipeline holds reset values early
    logic [4:0] rise_q; // Link rises seen inside the current frame
    wire        run = up_q >= 3'd4;
    // Helper counters
    always_ff @(posedge clk_i)
    begin
        up_q   <= !rstn_i ? 3'd0 : (up_q == 3'd7 ? up_q : up_q + 3'd1);
        rise_q <= (!rstn_i || !link_frame_o) ? 5'd0 : rise_q + 5'($rose(link_clk_o));
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence pin_bad;
        $past(mode_sel_i, 3) == 2'b10;
    endsequence
    chan_decode_a: assert property (run |->
        channel_o == {1'b0, ~$past(channel_choice_lines_i, 3)} + 4'h1) else $error("chan");
    mode_map_a: assert property (run && $past(mode_sel_i, 3) != 2'b10 |-> mode_o ==
        ($past(mode_sel_i, 3) == 2'b00 ? ERC_MODE_ANALOG :
        ($past(mode_sel_i, 3) == 2'b01 ? ERC_MODE_FSK2 : ERC_MODE_FSK4))) else $error("mode");
    mode_hold_a: assert property (run and pin_bad |-> $stable(mode_o)) else $error("hold");
    bad_flag_a: assert property (run |-> mode_invalid_o == ($past(mode_sel_i, 3) == 2'b10))
        else $error("invalid flag");
    no_local_a: assert property (mode_o != ERC_MODE_LOCAL) else $error("local");
    fsk_bits_a: assert property (run |-> fsk_data_o ==
        {2'b00, $past(fsk_symbol_bit_b_i, 3), $past(fsk_symbol_bit_a_i, 3)}) else $error("fsk");
    key_pass_a: assert property (run |-> key_o == $past(key_i, 3) &&
        pa_low_power_o == $past(pa_low_power_mode_i, 3)) else $error("key");
    fwd_write_a: assert property (power_wr_fwd_i && !power_wr_ref_i |=>
        forward_power_level_o == $past(power_data_i) && $stable(reflected_power_level_o))
        else $error("fwd");
    ref_write_a: assert property (power_wr_ref_i && !power_wr_fwd_i |=>
        reflected_power_level_o == $past(power_data_i) && $stable(forward_power_level_o))
        else $error("ref");
    no_write_a: assert property (power_wr_fwd_i == power_wr_ref_i |=>
        $stable(forward_power_level_o) && $stable(reflected_power_level_o)) else $error("nw");
    alarm_echo_a: assert property (run |-> $past(status_i) == {fault_alarm_o,
        mismatch_flag_o, low_power_alarm_o, shutdown_alarm_o, temp_alarm_o,
        rf_input_alarm_o, modulation_present_flag_o, tone_decoder_o}) else $error("alarm");
    audio_take_a: assert property (audio_valid_i && !audio_busy_o &&
        mode_o == ERC_MODE_ANALOG |=> audio_busy_o) else $error("take");
    frame_bits_a: assert property ($fell(link_frame_o) |-> rise_q == 5'd16)
        else $error("bits");
endmodule : erc_decoder_chk
bind erc_decoder erc_decoder_chk chk (.*);

// >>> erc_decoder_bench.sv
`timescale 1ns/1ps
module erc_decoder_bench
    import erc_pkg::*;
;
    logic        clk_i = 0, rstn_i = 0, fsk_symbol_bit_a_i = 0, fsk_symbol_bit_b_i = 0;
    logic        fsk_bit_d_or_strobe_i = 0, key_i = 0, pa_low_power_mode_i = 0, clr = 0;
    logic        audio_valid_i = 0, power_wr_fwd_i = 0, power_wr_ref_i = 0;
    logic [2:0]  channel_choice_lines_i = 3'h7;  // All open: channel one
    logic [1:0]  mode_sel_i = 2'h0;
    logic [15:0] audio_sample_i = 16'h0000, rx_word;
    logic [7:0]  power_data_i = 8'h00, forward_power_level_o, reflected_power_level_o;
    erc_status_s status_i = 8'h00;
    logic [3:0]  channel_o, fsk_data_o;
    logic [4:0]  rx_bits;
    erc_mode_e   mode_o;
    logic        mode_invalid_o, key_o, pa_low_power_o, link_clk_o, link_frame_o, link_data_o;
    logic        audio_busy_o, fault_alarm_o, mismatch_flag_o, low_power_alarm_o;
    logic        shutdown_alarm_o, temp_alarm_o, rf_input_alarm_o;
    logic        modulation_present_flag_o, tone_decoder_o;
    int          bad_count = 0, n_compared = 0;
    erc_decoder dut (.*);
    erc_link_rx rx (.clr_i(clr), .link_clk_i(link_clk_o), .link_frame_i(link_frame_o),
        .link_data_i(link_data_o), .word_o(rx_word), .bits_o(rx_bits));
    // Free clock, 8 ns period
    always #4 clk_i = ~clk_i;
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    // Inputs always move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Every channel code, active-low lines
    task automatic t_channel;
        for (int i = 0; i < 8; i++)
        begin
            channel_choice_lines_i = ~i[2:0];
            step(4);
            chk(channel_o, i + 1);
        end
        $display("channel test done");
    endtask : t_channel
    // Mode table incl. the undefined pattern, which must keep the last mode
    task automatic t_mode;
        logic [1:0] ms [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h2};
        logic [1:0] em [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};
        for (int i = 0; i < 6; i++)
        begin
            mode_sel_i = ms[i];
            {fsk_symbol_bit_b_i, fsk_symbol_bit_a_i} = i[1:0];
            {pa_low_power_mode_i, key_i} = ~i[1:0];
            step(4);
            chk(mode_o, em[i]);
            chk(mode_invalid_o, ms[i] == 2'h2);
            chk(fsk_data_o, i[1:0]);
            chk({pa_low_power_o, key_o}, 2'(~i[1:0]));
        end
        $display("mode test done");
    endtask : t_mode
    // Steering: each half alone, then both strobes together ignored
    task automatic t_power;
        logic [1:0] st [3] = '{2'b10, 2'b01, 2'b11};
        logic [7:0] dv [3] = '{8'hA5, 8'h3C, 8'hFF};
        for (int i = 0; i < 3; i++)
        begin
            {power_wr_fwd_i, power_wr_ref_i} = st[i];
            power_data_i = dv[i];
            step(1);
            {power_wr_fwd_i, power_wr_ref_i} = 2'b00;
            step(1);
        end
        chk(forward_power_level_o, 8'hA5);
        chk(reflected_power_level_o, 8'h3C);
        $display("power test done");
    endtask : t_power
    // Two complementary patterns so every alarm line is seen high and low
    task automatic t_status;
        logic [7:0] pat [2] = '{8'hA5, 8'h5A};
        for (int i = 0; i < 2; i++)
        begin
            status_i = pat[i];
            step(2);
            chk({fault_alarm_o, mismatch_flag_o, low_power_alarm_o, shutdown_alarm_o,
                temp_alarm_o, rf_input_alarm_o, modulation_present_flag_o,
                tone_decoder_o}, pat[i]);
        end
        $display("status test done");
    endtask : t_status
    // One sample in analog mode, then one refused in two-level mode
    task automatic t_audio(input logic [1:0] m, input logic take);
        int k;
        mode_sel_i = m;
        clr = 1;
        step(4);
        clr = 0;
        audio_sample_i = 16'hB38D;
        audio_valid_i = 1;
        step(1);
        audio_valid_i = 0;
        step(1);
        chk(audio_busy_o, take);
        for (k = 0; k < 1000 && audio_busy_o !== 1'b0; k++)
            step(1);
        if (k == 1000)
        begin
            bad_count++;
            summarize();
        end
        step(20);
        chk(rx_bits, take ? 16 : 0);
        if (take)
            chk(rx_word, 16'hB38D);
        $display("audio test done");
    endtask : t_audio
    initial
    begin
        step(5);
        rstn_i = 1;
        t_channel();
        t_mode();
        t_power();
        t_status();
        t_audio(2'h0, 1'b1);
        t_audio(2'h1, 1'b0);
        summarize();
    end
endmodule : erc_decoder_bench
